// File: par_pkg.sv
package par_pkg;

   // Register window offsets
   localparam logic [11:0] OFF_START = 12'h000;
   localparam logic [11:0] OFF_STOP = 12'h008;
   localparam logic [11:0] OFF_EV_DONE = 12'h100;
   localparam logic [11:0] OFF_EV_MATCH = 12'h104;
   localparam logic [11:0] OFF_EV_NOMATCH = 12'h108;
   localparam logic [11:0] OFF_MASK_SET = 12'h304;
   localparam logic [11:0] OFF_MASK_CLR = 12'h308;
   localparam logic [11:0] OFF_STATUS = 12'h400;
   localparam logic [11:0] OFF_ENABLE = 12'h500;
   localparam logic [11:0] OFF_KEY_COUNT = 12'h504;
   localparam logic [11:0] OFF_KEY_PTR = 12'h508;
   localparam logic [11:0] OFF_ADDR_PTR = 12'h510;
   localparam logic [11:0] OFF_SCR_PTR = 12'h514;

   // Event bit positions in flags and mask
   localparam int EV_DONE = 0;
   localparam int EV_MATCH = 1;
   localparam int EV_NOMATCH = 2;
   localparam int EV_NUM = 3;

   // Peripheral placement
   localparam logic [31:0] PERIPH_BASE0 = 32'h4000_0000;
   localparam logic [31:0] PERIPH_SPAN = 32'h0000_1000;
   localparam logic [31:0] RESOLVER_BASE = 32'h4000_F000;
   localparam logic [4:0] IRQ_ID = 5'((RESOLVER_BASE - PERIPH_BASE0) / PERIPH_SPAN);

   // Field values and reset values
   localparam logic [1:0] ENABLE_ON = 2'h3;
   localparam logic [1:0] ENABLE_RST = 2'h0;
   localparam logic [4:0] KEY_COUNT_RST = 5'h01;
   localparam logic [4:0] KEY_COUNT_MIN = 5'h01;

   // Memory layout and cipher constants
   localparam logic [3:0] ADDR_LAST = 4'h5;
   localparam logic [3:0] KEY_LAST = 4'hf;
   localparam logic [3:0] SCR_LAST = 4'h2;
   localparam logic [3:0] AES_ROUNDS = 4'ha;
   localparam logic [7:0] RCON_FIRST = 8'h01;
   localparam logic [7:0] AES_POLY = 8'h1b;
   localparam logic [7:0] AFFINE_C = 8'h63;

   typedef enum logic [5:0] {
      S_IDLE = 6'b00_0001,
      S_RD_ADDR = 6'b00_0010,
      S_RD_KEY = 6'b00_0100,
      S_CIPHER = 6'b00_1000,
      S_WR_SCR = 6'b01_0000,
      S_DONE = 6'b10_0000
   } par_state_t;

endpackage

// File: par_address_resolver.sv
// How it works
// - Start on trigger write or task strobe
// - Event flag stays set until written zero
// - Event strobes fire even if flag set
// - Masked events drive the single interrupt
// - Window 0x1000 bytes, base 0x4000F000
// - Interrupt number equals peripheral identifier
// - Mask set and clear read the mask
// - Write one sets or clears mask bit
// - Interrupt may lag clear by four cycles
// - Address pointer at packet; start begins
// - Keys tried ascending from zero, count limited
// - Key n at pointer plus sixteen n
// - Match raises resolved, else not resolved
// - Stop at first match or last key
// - End event follows the outcome
// - Address type bits never examined
// - Memory traffic done before any event
// - Recompute hash from random part, compare
// - Enable value three activates, zero disables
// - Status holds last matching key index
// - Key count accepts one to sixteen
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module par_address_resolver #(
   parameter int MAX_KEYS = 16
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic start_strobe,
   input wire logic stop_strobe,
   output logic done_pulse,
   output logic match_pulse,
   output logic nomatch_pulse,
   output logic irq,
   output logic [4:0] irq_number,
   output logic dma_req,
   output logic dma_we,
   output logic [31:0] dma_addr,
   output logic [7:0] dma_wdata,
   input wire logic dma_ack,
   input wire logic [7:0] dma_rdata
);
   import par_pkg::*;

   if (MAX_KEYS < 1 || MAX_KEYS > 16) begin : g_bad_keys
      $error("MAX_KEYS must lie in 1..16");
   end

   typedef struct packed {
      par_state_t st;
      logic [1:0] enable;
      logic [4:0] key_count;
      logic [31:0] key_ptr;
      logic [31:0] addr_ptr;
      logic [31:0] scr_ptr;
      logic [EV_NUM-1:0] ev_flag;
      logic [EV_NUM-1:0] irq_mask;
      logic [EV_NUM-1:0] ev_pulse;
      logic [3:0] match_idx;
      logic [47:0] addr;
      logic [127:0] key;
      logic [127:0] aes;
      logic [127:0] rkey;
      logic [7:0] rcon;
      logic [3:0] rnd;
      logic [3:0] cnt;
      logic [3:0] key_idx;
      logic dma_req;
      logic dma_we;
      logic [31:0] dma_addr;
      logic [7:0] dma_wdata;
      logic irq;
      logic [4:0] irq_id;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } par_regs_t;

   localparam par_regs_t RST = '{
      st: S_IDLE,
      enable: ENABLE_RST,
      key_count: KEY_COUNT_RST,
      irq_id: IRQ_ID,
      default: '0
   };

   ////////////////////////////////////////////////////////////////////////
   // Cipher helpers

   function automatic logic [7:0] xt(input logic [7:0] b);
      return {b[6:0], 1'b0} ^ (b[7] ? AES_POLY : 8'h00);
   endfunction

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            p = p ^ x;
         end
         x = xt(x);
      end
      return p;
   endfunction

   // Inverse by x^254 saves a 256-entry table at the cost of depth
   function automatic logic [7:0] sbox(input logic [7:0] x);
      logic [7:0] r;
      r = x;
      for (int i = 0; i < 6; i++) begin
         r = gmul(gmul(r, r), x);
      end
      r = gmul(r, r);
      return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ AFFINE_C;
   endfunction

   function automatic logic [127:0] key_next(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] w3;
      logic [31:0] t;
      logic [31:0] n0;
      logic [31:0] n1;
      logic [31:0] n2;
      w3 = k[31:0];
      t = {sbox(w3[23:16]), sbox(w3[15:8]), sbox(w3[7:0]), sbox(w3[31:24])} ^ {rc, 24'h0};
      n0 = k[127:96] ^ t;
      n1 = k[95:64] ^ n0;
      n2 = k[63:32] ^ n1;
      return {n0, n1, n2, w3 ^ n2};
   endfunction

   // Byte i of the block sits at index 15-i
   function automatic logic [127:0] aes_round(input logic [127:0] st, input logic [127:0] rk,
                                              input logic last);
      logic [15:0][7:0] s;
      logic [15:0][7:0] t;
      logic [15:0][7:0] m;
      logic [7:0] a0;
      logic [7:0] a1;
      logic [7:0] a2;
      logic [7:0] a3;
      s = st;
      for (int i = 0; i < 16; i++) begin
         s[i] = sbox(s[i]);
      end
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 4; c++) begin
            t[15-(r+4*c)] = s[15-(r+4*((c+r)%4))];
         end
      end
      for (int c = 0; c < 4; c++) begin
         a0 = t[15-4*c];
         a1 = t[14-4*c];
         a2 = t[13-4*c];
         a3 = t[12-4*c];
         m[15-4*c] = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
         m[14-4*c] = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
         m[13-4*c] = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
         m[12-4*c] = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
      end
      return (last ? t : m) ^ rk;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   par_regs_t r;
   par_regs_t n;
   logic acc;
   logic wr;
   logic go_sw;
   logic stop_sw;
   logic running;
   logic go;
   logic halt;
   logic [EV_NUM-1:0] ev_set;
   logic [127:0] key_full;
   logic [127:0] rkey_nxt;
   logic [127:0] round_out;

   assign key_full = {r.key[119:0], dma_rdata};
   assign rkey_nxt = key_next(r.rkey, r.rcon);
   assign round_out = aes_round(r.aes, rkey_nxt, r.rnd == AES_ROUNDS);

   always_comb begin
      n = r;
      ev_set = '0;
      go_sw = 1'b0;
      stop_sw = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      acc = psel & penable & ~r.pready;
      wr = acc & pwrite;
      // Answer one cycle into the access phase
      if (acc) begin
         n.pready = 1'b1;
         n.prdata = '0;
         case (paddr)
            OFF_START: go_sw = wr & pwdata[0];
            OFF_STOP: stop_sw = wr & pwdata[0];
            OFF_EV_DONE, OFF_EV_MATCH, OFF_EV_NOMATCH: begin
               n.prdata[0] = r.ev_flag[paddr[3:2]];
               if (wr) begin
                  n.ev_flag[paddr[3:2]] = pwdata[0];
               end
            end
            OFF_MASK_SET: begin
               n.prdata[EV_NUM-1:0] = r.irq_mask;
               if (wr) begin
                  n.irq_mask = r.irq_mask | pwdata[EV_NUM-1:0];
               end
            end
            OFF_MASK_CLR: begin
               n.prdata[EV_NUM-1:0] = r.irq_mask;
               if (wr) begin
                  n.irq_mask = r.irq_mask & ~pwdata[EV_NUM-1:0];
               end
            end
            OFF_STATUS: n.prdata[3:0] = r.match_idx;
            OFF_ENABLE: begin
               n.prdata[1:0] = r.enable;
               if (wr) begin
                  n.enable = pwdata[1:0];
               end
            end
            OFF_KEY_COUNT: begin
               n.prdata[4:0] = r.key_count;
               // Out-of-range counts are dropped, the old count stays
               if (wr && pwdata >= 32'(KEY_COUNT_MIN) && pwdata <= 32'(MAX_KEYS)) begin
                  n.key_count = pwdata[4:0];
               end
            end
            OFF_KEY_PTR: begin
               n.prdata = r.key_ptr;
               if (wr) begin
                  n.key_ptr = pwdata;
               end
            end
            OFF_ADDR_PTR: begin
               n.prdata = r.addr_ptr;
               if (wr) begin
                  n.addr_ptr = pwdata;
               end
            end
            OFF_SCR_PTR: begin
               n.prdata = r.scr_ptr;
               if (wr) begin
                  n.scr_ptr = pwdata;
               end
            end
            default: n.pslverr = 1'b1;
         endcase
      end

      running = r.enable == ENABLE_ON;
      go = running & (go_sw | start_strobe);
      halt = stop_sw | stop_strobe | ~running;

      unique case (r.st)
         S_IDLE: begin
            if (go && !halt) begin
               n.st = S_RD_ADDR;
               n.cnt = '0;
               n.key_idx = '0;
            end
         end
         S_RD_ADDR: begin
            if (!r.dma_req) begin
               n.dma_req = 1'b1;
               n.dma_we = 1'b0;
               n.dma_addr = r.addr_ptr + {28'h0, r.cnt};
            end else if (dma_ack) begin
               n.dma_req = 1'b0;
               n.addr = {dma_rdata, r.addr[47:8]};
               n.cnt = r.cnt + 4'h1;
               if (r.cnt == ADDR_LAST) begin
                  n.st = S_RD_KEY;
                  n.cnt = '0;
               end
            end
         end
         S_RD_KEY: begin
            if (!r.dma_req) begin
               n.dma_req = 1'b1;
               n.dma_we = 1'b0;
               n.dma_addr = r.key_ptr + {24'h0, r.key_idx, 4'h0} + {28'h0, r.cnt};
            end else if (dma_ack) begin
               n.dma_req = 1'b0;
               n.key = key_full;
               n.cnt = r.cnt + 4'h1;
               if (r.cnt == KEY_LAST) begin
                  // Random part zero-padded; type bits pass unexamined
                  n.aes = {104'h0, r.addr[47:24]} ^ key_full;
                  n.rkey = key_full;
                  n.rcon = RCON_FIRST;
                  n.rnd = 4'h1;
                  n.st = S_CIPHER;
               end
            end
         end
         S_CIPHER: begin
            n.aes = round_out;
            n.rkey = rkey_nxt;
            n.rcon = xt(r.rcon);
            n.rnd = r.rnd + 4'h1;
            if (r.rnd == AES_ROUNDS) begin
               n.st = S_WR_SCR;
               n.cnt = '0;
            end
         end
         S_WR_SCR: begin
            // Hash parked in scratch before the verdict
            if (!r.dma_req) begin
               n.dma_req = 1'b1;
               n.dma_we = 1'b1;
               n.dma_addr = r.scr_ptr + {28'h0, r.cnt};
               n.dma_wdata = r.aes[{r.cnt[1:0], 3'b000} +: 8];
            end else if (dma_ack) begin
               n.dma_req = 1'b0;
               n.dma_we = 1'b0;
               n.cnt = r.cnt + 4'h1;
               if (r.cnt == SCR_LAST) begin
                  if (r.aes[23:0] == r.addr[23:0]) begin
                     ev_set[EV_MATCH] = 1'b1;
                     n.match_idx = r.key_idx;
                     n.st = S_DONE;
                  end else if ({1'b0, r.key_idx} + 5'h01 >= r.key_count) begin
                     ev_set[EV_NOMATCH] = 1'b1;
                     n.st = S_DONE;
                  end else begin
                     n.key_idx = r.key_idx + 4'h1;
                     n.cnt = '0;
                     n.st = S_RD_KEY;
                  end
               end
            end
         end
         S_DONE: begin
            ev_set[EV_DONE] = 1'b1;
            n.st = S_IDLE;
         end
         default: n.st = S_IDLE;
      endcase

      // Stop or disable withdraws any pending memory request
      if (halt && r.st != S_IDLE) begin
         n.st = S_IDLE;
         n.dma_req = 1'b0;
         n.dma_we = 1'b0;
         ev_set = '0;
      end

      // Hardware set wins over a software clear in the same cycle
      n.ev_flag = n.ev_flag | ev_set;
      n.ev_pulse = ev_set;
      // Registered from the next flags, so the line falls in the same cycle as the clear
      n.irq = |(n.ev_flag & n.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign done_pulse = r.ev_pulse[EV_DONE];
   assign match_pulse = r.ev_pulse[EV_MATCH];
   assign nomatch_pulse = r.ev_pulse[EV_NOMATCH];
   assign irq = r.irq;
   assign irq_number = r.irq_id;
   assign dma_req = r.dma_req;
   assign dma_we = r.dma_we;
   assign dma_addr = r.dma_addr;
   assign dma_wdata = r.dma_wdata;

endmodule

`default_nettype wire

// File: par_chk.sv
`timescale 1ns/100ps
`default_nettype none
module par_chk (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [4:0] irq_number,
   input wire logic dma_req,
   input wire logic dma_we,
   input wire logic [31:0] dma_addr,
   input wire logic [7:0] dma_wdata,
   input wire logic dma_ack,
   input wire logic done_pulse,
   input wire logic match_pulse,
   input wire logic nomatch_pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("bus answer late");
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("bus answer too long");
   err_with_ready_a: assert property (pslverr |-> pready && psel)
      else $error("stray bus error");
   irq_number_a: assert property (irq_number == 5'h0f)
      else $error("wrong interrupt number");
   dma_hold_a: assert property (dma_req && !dma_ack |=>
      !dma_req || $stable(dma_addr) && $stable(dma_we) && $stable(dma_wdata))
      else $error("memory request changed");
   dma_gap_a: assert property (dma_req && dma_ack |=> !dma_req)
      else $error("memory request not released");
   end_follows_a: assert property (match_pulse || nomatch_pulse |=> done_pulse)
      else $error("end event missing");
   end_cause_a: assert property (done_pulse |-> $past(match_pulse || nomatch_pulse))
      else $error("end event without outcome");
   one_outcome_a: assert property (!(match_pulse && nomatch_pulse))
      else $error("both outcomes");
   quiet_bus_a: assert property (done_pulse || match_pulse || nomatch_pulse |-> !dma_req)
      else $error("memory busy at event");
endmodule
bind par_address_resolver par_chk chk_u (.clock, .reset_n, .psel, .penable, .pready, .pslverr,
   .irq_number, .dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_ack, .done_pulse, .match_pulse,
   .nomatch_pulse);
`default_nettype wire

// File: par_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module par_ram_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic slow,
   input wire logic dma_req,
   input wire logic dma_we,
   input wire logic [31:0] dma_addr,
   input wire logic [7:0] dma_wdata,
   output logic dma_ack,
   output logic [7:0] dma_rdata
);
   logic [7:0] ram [0:1023];
   int n_rd;
   int cnt;
   logic [31:0] last_rd;
   // Data line toggles when idle, so a stale byte never looks valid
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dma_ack <= 1'b0;
         dma_rdata <= 8'h00;
         cnt <= 0;
         n_rd <= 0;
         last_rd <= 32'h0000_0000;
      end else if (dma_ack) begin
         dma_ack <= 1'b0;
         dma_rdata <= ~dma_rdata;
         cnt <= 0;
         if (dma_req && dma_we) begin
            ram[dma_addr[9:0]] <= dma_wdata;
         end
         if (dma_req && !dma_we) begin
            n_rd <= n_rd + 1;
            last_rd <= dma_addr;
         end
      end else if (dma_req && cnt >= (slow ? 3 : 0)) begin
         dma_ack <= 1'b1;
         dma_rdata <= ram[dma_addr[9:0]];
      end else begin
         cnt <= dma_req ? cnt + 1 : 0;
         dma_rdata <= ~dma_rdata;
      end
   end
endmodule
`default_nettype wire

// File: tb_par_address_resolver.sv
`timescale 1ns/100ps
`default_nettype none
module tb_par_address_resolver;
   import par_pkg::*;
   logic clock = 0;
   logic reset_n = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic start_strobe = 0;
   logic stop_strobe = 0;
   logic slow = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, dma_addr, r;
   logic pready, pslverr, done_pulse, match_pulse, nomatch_pulse, irq, dma_req, dma_we, dma_ack, er;
   logic [4:0] irq_number;
   logic [7:0] dma_wdata, dma_rdata;
   int err_count = 0;
   int n_checks = 0;
   int base;
   int n;
   int n_hit = 0;
   int n_miss = 0;

   par_address_resolver #(.MAX_KEYS(16)) dut_u (.clock, .reset_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .start_strobe, .stop_strobe, .done_pulse,
      .match_pulse, .nomatch_pulse, .irq, .irq_number, .dma_req, .dma_we, .dma_addr, .dma_wdata,
      .dma_ack, .dma_rdata);
   par_ram_model mem_u (.clock, .reset_n, .slow, .dma_req, .dma_we, .dma_addr, .dma_wdata,
      .dma_ack, .dma_rdata);

   initial forever #20 clock = ~clock;
   // Outcome strobes counted, flags alone cannot show a repeat
   always @(posedge clock) begin
      if (match_pulse === 1'b1) begin
         n_hit <= n_hit + 1;
      end
      if (nomatch_pulse === 1'b1) begin
         n_miss <= n_miss + 1;
      end
   end
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 40);
      if (pready !== 1'b1) begin
         err_count++;
         summarize;
      end
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, e);
   endtask
   task automatic pulse_start;
      start_strobe <= 1'b1;
      @(posedge clock);
      start_strobe <= 1'b0;
   endtask
   // Bounded wait, a hang ends the run as a mismatch
   task automatic wait_done(input int lim);
      n = 0;
      while (done_pulse !== 1'b1 && n < lim) begin
         @(posedge clock);
         n++;
      end
      if (done_pulse !== 1'b1) begin
         err_count++;
         summarize;
      end
   endtask

   initial begin
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      rd(OFF_KEY_COUNT, 32'h0000_0001);
      rd(OFF_ENABLE, 32'h0000_0000);
      rd(OFF_STATUS, 32'h0000_0000);
      rd(OFF_EV_DONE, 32'h0000_0000);
      chk(32'(irq_number), 32'h0000_000f);
      rd(12'h00c, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001);
      wr(OFF_KEY_COUNT, 32'h0000_0000);
      wr(OFF_KEY_COUNT, 32'h0000_0011);
      rd(OFF_KEY_COUNT, 32'h0000_0001);
      wr(OFF_MASK_SET, 32'h0000_0007);
      wr(OFF_MASK_CLR, 32'h0000_0002);
      wr(OFF_MASK_SET, 32'h0000_0000);
      rd(OFF_MASK_SET, 32'h0000_0005);
      rd(OFF_MASK_CLR, 32'h0000_0005);
      $display("registers test done");
      for (int i = 0; i < 256; i++) mem_u.ram[256 + i] = 8'(i * 7 + 3);
      for (int i = 0; i < 6; i++) mem_u.ram[32 + i] = (i < 3) ? 8'h00 : 8'(8'hc1 - i);
      wr(OFF_KEY_PTR, 32'h0000_0100);
      wr(OFF_ADDR_PTR, 32'h0000_0020);
      wr(OFF_SCR_PTR, 32'h0000_0040);
      wr(OFF_KEY_COUNT, 32'h0000_0003);
      base = mem_u.n_rd;
      pulse_start();
      wr(OFF_ENABLE, 32'h0000_0001);
      wr(OFF_START, 32'h0000_0001);
      chk(32'(mem_u.n_rd - base), 32'h0000_0000);
      wr(OFF_ENABLE, 32'h0000_0003);
      pulse_start();
      wait_done(3000);
      chk(32'(mem_u.n_rd - base), 32'h0000_0036);
      chk(mem_u.last_rd, 32'h0000_012f);
      chk(32'(n_miss), 32'h0000_0001);
      chk(32'(n_hit), 32'h0000_0000);
      rd(OFF_EV_NOMATCH, 32'h0000_0001);
      rd(OFF_EV_MATCH, 32'h0000_0000);
      rd(OFF_EV_DONE, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      wr(OFF_EV_DONE, 32'h0000_0000);
      rd(OFF_EV_DONE, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0001);
      wr(OFF_EV_NOMATCH, 32'h0000_0000);
      repeat (4) @(posedge clock);
      chk(32'(irq), 32'h0000_0000);
      $display("no match test done");
      // Reuse the last hash to build an address that key two resolves
      for (int i = 0; i < 3; i++) mem_u.ram[32 + i] = mem_u.ram[64 + i];
      wr(OFF_KEY_COUNT, 32'h0000_0005);
      slow <= 1'b1;
      base = mem_u.n_rd;
      wr(OFF_START, 32'h0000_0001);
      wait_done(6000);
      chk(32'(mem_u.n_rd - base), 32'h0000_0036);
      rd(OFF_STATUS, 32'h0000_0002);
      rd(OFF_EV_MATCH, 32'h0000_0001);
      rd(OFF_EV_NOMATCH, 32'h0000_0000);
      chk(32'(n_hit), 32'h0000_0001);
      wr(OFF_START, 32'h0000_0001);
      wait_done(6000);
      rd(OFF_STATUS, 32'h0000_0002);
      chk(32'(n_hit), 32'h0000_0002);
      $display("match test done");
      wr(OFF_EV_DONE, 32'h0000_0000);
      wr(OFF_EV_MATCH, 32'h0000_0000);
      // Strobe stop first, then register stop; the wait outlasts a whole run
      for (int v = 0; v < 2; v++) begin
         base = mem_u.n_rd;
         pulse_start();
         n = 0;
         while (mem_u.n_rd - base < 3 && n < 500) begin
            @(posedge clock);
            n++;
         end
         if (mem_u.n_rd - base < 3) begin
            err_count++;
            summarize;
         end
         if (v == 0) begin
            stop_strobe <= 1'b1;
            @(posedge clock);
            stop_strobe <= 1'b0;
         end else begin
            wr(OFF_STOP, 32'h0000_0001);
         end
         repeat (4) @(posedge clock);
         base = mem_u.n_rd;
         repeat (600) @(posedge clock);
         chk(32'(mem_u.n_rd - base), 32'h0000_0000);
         chk(32'(dma_req), 32'h0000_0000);
      end
      rd(OFF_EV_DONE, 32'h0000_0000);
      rd(OFF_EV_MATCH, 32'h0000_0000);
      rd(OFF_EV_NOMATCH, 32'h0000_0000);
      chk(32'(n_hit), 32'h0000_0002);
      chk(32'(n_miss), 32'h0000_0001);
      $display("stop test done");
      summarize;
   end
endmodule
`default_nettype wire
